/* File: alu_multiply_subtract_ops.sv */
// execution datapath: bit ops, watchdog clear, invert, multiply, subtract, table read
`timescale 1ns/1ps
`include "alu_ops_defines.svh"

module alu_multiply_subtract_ops (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic [31:0]                 hrdata,
	output logic                        hresp,
	input  wire alu_ops_pkg::op_req_t   op,
	input  wire logic [7:0]             file_rdata,
	output logic [15:0]                 prog_addr,
	input  wire logic [15:0]            prog_rdata,
	output alu_ops_pkg::file_wr_t       file_wr,
	output logic [7:0]                  working_value
);

	alu_ops_pkg::state_t s_q;
	alu_ops_pkg::state_t s_d;

	logic [7:0]  res;
	logic [8:0]  sub_full;
	logic [4:0]  sub_nib;
	logic        cin;
	logic [15:0] mul_a;
	logic [7:0]  mul_b;
	logic        take;

	// ===========================================================
	// outputs
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hrdata        = s_q.rdata;
	assign file_wr       = s_q.fwr;
	assign prog_addr     = s_q.table_pointer;
	assign working_value = s_q.working_register;

	// ===========================================================
	// next state
	always_comb begin
		s_d        = s_q;
		s_d.fwr.we = 1'b0;
		res        = 8'h00;
		mul_b      = (op.code == alu_ops_pkg::multiply_literal_op) ? op.operand : file_rdata;
		mul_a      = 16'(s_q.working_register) * 16'(mul_b);
		cin        = (op.code == alu_ops_pkg::subtract_with_borrow_op) ? s_q.c : 1'b1;
		// invert at operand width first, so the widened top bit stays clear
		sub_full   = 9'(file_rdata) + {1'b0, ~s_q.working_register} + 9'(cin);
		sub_nib    = 5'(file_rdata[3:0]) + {1'b0, ~s_q.working_register[3:0]} + 5'(cin);
		take       = hsel && hready && htrans[1];

		// watchdog runs freely; a full wrap marks expiry
		s_d.wdt_post = s_q.wdt_post + 4'h1;
		if (s_q.wdt_post == 4'hF) begin
			s_d.wdt = s_q.wdt + 8'h01;
			if (s_q.wdt == 8'hFF) begin
				s_d.watchdog_expired_flag = 1'b0;
			end
		end

		// bus data phase write
		if (s_q.ph_write) begin
			unique case (s_q.ph_addr)
				`OFF_WORKING:   s_d.working_register = hwdata[7:0];
				`OFF_FLAGS: begin
					s_d.c  = hwdata[`FLAG_C_BIT];
					s_d.dc = hwdata[`FLAG_DC_BIT];
					s_d.z  = hwdata[`FLAG_Z_BIT];
					s_d.ov = hwdata[`FLAG_OV_BIT];
				end
				`OFF_TABLE_PTR: s_d.table_pointer = hwdata[15:0];
				default: ;
			endcase
		end

		// operation execute; overrides a bus write in the same cycle
		if (op.valid) begin
			unique case (op.code)
				alu_ops_pkg::bit_set_op,
				alu_ops_pkg::bit_clear_op,
				alu_ops_pkg::bit_toggle_op: begin
					res = file_rdata;
					if (op.code == alu_ops_pkg::bit_set_op) begin
						res[op.bit_sel] = 1'b1;
					end else if (op.code == alu_ops_pkg::bit_clear_op) begin
						res[op.bit_sel] = 1'b0;
					end else begin
						res[op.bit_sel] = ~file_rdata[op.bit_sel];
					end
					s_d.fwr = '{we: 1'b1, addr: op.operand, data: res};
				end
				alu_ops_pkg::watchdog_clear_op: begin
					s_d.wdt                   = `WDT_CLEAR_VAL;
					s_d.wdt_post              = `WDT_POST_CLEAR;
					s_d.watchdog_expired_flag = `STATUS_SET_VAL;
					s_d.sleep_entered_flag    = `STATUS_SET_VAL;
				end
				alu_ops_pkg::invert_file_op: begin
					res   = ~file_rdata;
					s_d.z = (res == 8'h00);
				end
				alu_ops_pkg::multiply_literal_op,
				alu_ops_pkg::multiply_working_by_file_op: begin
					s_d.product = mul_a;
				end
				alu_ops_pkg::subtract_working_from_file_op,
				alu_ops_pkg::subtract_with_borrow_op: begin
					res    = sub_full[7:0];
					s_d.c  = sub_full[8];
					s_d.dc = sub_nib[4];
					s_d.z  = (res == 8'h00);
					s_d.ov = (file_rdata[7] != s_q.working_register[7]) && (res[7] != file_rdata[7]);
				end
				alu_ops_pkg::table_read_op: begin
					res = op.tbl_high ? s_q.table_latch[15:8] : s_q.table_latch[7:0];
					s_d.fwr         = '{we: 1'b1, addr: op.operand, data: res};
					s_d.table_latch = prog_rdata;
					if (op.tbl_inc) begin
						s_d.table_pointer = s_q.table_pointer + 16'h0001;
					end
				end
				default: ;
			endcase
			// destination select for ops that carry it
			if (op.code == alu_ops_pkg::invert_file_op ||
			    op.code == alu_ops_pkg::subtract_working_from_file_op ||
			    op.code == alu_ops_pkg::subtract_with_borrow_op) begin
				if (op.dest) begin
					s_d.fwr = '{we: 1'b1, addr: op.operand, data: res};
				end else begin
					s_d.working_register = res;
				end
			end
		end

		// bus address phase: capture and read with forwarding
		s_d.ph_write = take && hwrite;
		s_d.ph_addr  = haddr[7:0];
		if (take && !hwrite) begin
			unique case (haddr[7:0])
				`OFF_WORKING:     s_d.rdata = {24'h000000, s_d.working_register};
				`OFF_PRODUCT:     s_d.rdata = {16'h0000, s_d.product};
				`OFF_FLAGS:       s_d.rdata = {26'h0000000, s_d.watchdog_expired_flag, s_d.sleep_entered_flag,
				                               s_d.ov, s_d.z, s_d.dc, s_d.c};
				`OFF_TABLE_PTR:   s_d.rdata = {16'h0000, s_d.table_pointer};
				`OFF_TABLE_LATCH: s_d.rdata = {16'h0000, s_d.table_latch};
				`OFF_WATCHDOG:    s_d.rdata = {24'h000000, s_d.wdt};
				default:          s_d.rdata = 32'h00000000;
			endcase
		end else begin
			s_d.rdata = 32'h00000000;
		end
	end

	// ===========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q                       <= '0;
			s_q.working_register      <= `WORKING_RST;
			s_q.watchdog_expired_flag <= `STATUS_SET_VAL;
			s_q.sleep_entered_flag    <= `STATUS_SET_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	// ===========================================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic op_mul;
	logic no_bus_wr;
	assign op_mul    = op.valid && (op.code == alu_ops_pkg::multiply_literal_op ||
	                               op.code == alu_ops_pkg::multiply_working_by_file_op);
	assign no_bus_wr = !s_q.ph_write;

	a_bit_rmw_write: assert property (
		op.valid && op.code == alu_ops_pkg::bit_toggle_op |=> file_wr.we && file_wr.addr == $past(op.operand)
		&& (file_wr.data ^ $past(file_rdata)) == (8'h01 << $past(op.bit_sel)))
		else $error("bit toggle did not rewrite one bit");
	a_wdt_clear_zero: assert property (
		op.valid && op.code == alu_ops_pkg::watchdog_clear_op |=> s_q.wdt == 8'h00 && s_q.wdt_post == 4'h0
		##0 s_q.watchdog_expired_flag && s_q.sleep_entered_flag)
		else $error("watchdog clear incomplete");
	a_invert_flags_kept: assert property (
		op.valid && op.code == alu_ops_pkg::invert_file_op && no_bus_wr |=> $stable(s_q.c) && $stable(s_q.ov)
		&& $stable(s_q.dc) && s_q.z == ($past(file_rdata) == 8'hFF))
		else $error("invert changed wrong flags");
	a_dest_working_route: assert property (
		op.valid && op.code == alu_ops_pkg::invert_file_op && !op.dest |=> !file_wr.we
		&& s_q.working_register == ~$past(file_rdata))
		else $error("dest zero not routed to working register");
	a_dest_file_route: assert property (
		op.valid && op.code == alu_ops_pkg::invert_file_op && op.dest |=> file_wr.we
		&& file_wr.data == ~$past(file_rdata))
		else $error("dest one not routed to file");
	a_mul_product_value: assert property (
		op.valid && op.code == alu_ops_pkg::multiply_literal_op |=>
		s_q.product == $past(s_q.working_register) * $past(op.operand))
		else $error("literal product wrong");
	a_mul_working_kept: assert property (
		op_mul && no_bus_wr |=> $stable(s_q.working_register) && s_q.product[15:8] ==
		16'($past(s_q.working_register) * $past(mul_b)) >> 8)
		else $error("multiply disturbed working register");
	a_mul_flags_kept: assert property (
		op_mul && no_bus_wr |=> $stable({s_q.ov, s_q.z, s_q.dc, s_q.c}))
		else $error("multiply changed flags");
	a_sub_borrow_value: assert property (
		op.valid && op.code == alu_ops_pkg::subtract_with_borrow_op && !op.dest |=>
		s_q.working_register == 8'($past(file_rdata) - $past(s_q.working_register) - 8'(!$past(s_q.c))))
		else $error("subtract with borrow wrong");
	a_sub_carry_flag: assert property (
		op.valid && op.code == alu_ops_pkg::subtract_working_from_file_op |=>
		s_q.c == ($past(file_rdata) >= $past(s_q.working_register)))
		else $error("subtract carry wrong");
	a_table_ptr_inc: assert property (
		op.valid && op.code == alu_ops_pkg::table_read_op && op.tbl_inc && no_bus_wr |=>
		s_q.table_pointer == $past(s_q.table_pointer) + 16'h0001 && s_q.table_latch == $past(prog_rdata))
		else $error("table read pointer or latch wrong");

	c_multiply_file: cover property (op.valid && op.code == alu_ops_pkg::multiply_working_by_file_op);
	c_sub_borrow_neg: cover property (op.valid && op.code == alu_ops_pkg::subtract_with_borrow_op ##1 !s_q.c);
	c_wdt_clear: cover property (op.valid && op.code == alu_ops_pkg::watchdog_clear_op);
	c_table_read: cover property (op.valid && op.code == alu_ops_pkg::table_read_op && op.tbl_inc);

endmodule

/* File: alu_ops_defines.svh */
// register offsets, flag bit positions, reset values for the multiply/subtract datapath
`ifndef ALU_OPS_DEFINES_SVH
`define ALU_OPS_DEFINES_SVH

// ===========================================================
// register byte offsets
`define OFF_WORKING      8'h00
`define OFF_PRODUCT      8'h04
`define OFF_FLAGS        8'h08
`define OFF_TABLE_PTR    8'h0C
`define OFF_TABLE_LATCH  8'h10
`define OFF_WATCHDOG     8'h14

// ===========================================================
// arith flags register field positions
`define FLAG_C_BIT       0
`define FLAG_DC_BIT      1
`define FLAG_Z_BIT       2
`define FLAG_OV_BIT      3
`define FLAG_PD_BIT      4
`define FLAG_TO_BIT      5

// ===========================================================
// reset and clear values
`define WORKING_RST      8'h00
`define WDT_CLEAR_VAL    8'h00
`define WDT_POST_CLEAR   4'h0
`define STATUS_SET_VAL   1'b1

`endif

/* File: alu_ops_pkg.sv */
// types shared by the multiply/subtract datapath
package alu_ops_pkg;

	// ===========================================================
	// operation codes from the instruction sequencer
	typedef enum logic [3:0] {
		bit_set_op                    = 4'h0,
		bit_clear_op                  = 4'h1,
		bit_toggle_op                 = 4'h2,
		watchdog_clear_op             = 4'h3,
		invert_file_op                = 4'h4,
		multiply_literal_op           = 4'h5,
		multiply_working_by_file_op   = 4'h6,
		subtract_working_from_file_op = 4'h7,
		subtract_with_borrow_op       = 4'h8,
		table_read_op                 = 4'h9
	} op_code_t;

	// decoded operation request
	typedef struct packed {
		logic       valid;
		op_code_t   code;
		logic [7:0] operand;   // literal, or file address
		logic       dest;      // 0 working register, 1 file
		logic [2:0] bit_sel;
		logic       tbl_high;  // table read half select
		logic       tbl_inc;
	} op_req_t;

	// file register write port
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} file_wr_t;

	// complete module state
	typedef struct packed {
		logic [7:0]  working_register;
		logic [15:0] product;          // high byte : low byte
		logic        ov;
		logic        z;
		logic        dc;
		logic        c;
		logic        watchdog_expired_flag;
		logic        sleep_entered_flag;
		logic [15:0] table_pointer;
		logic [15:0] table_latch;      // high : low
		logic [7:0]  wdt;
		logic [3:0]  wdt_post;
		logic        ph_write;         // pending bus write data phase
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
		file_wr_t    fwr;
	} state_t;

endpackage

/* File: alu_ops_partner.sv */
// file register and program memory model facing the datapath
`timescale 1ns/1ps
module alu_ops_partner (
	input  wire logic                  hclk,
	input  wire logic [7:0]            rd_addr,
	output logic [7:0]                 file_rdata,
	input  wire alu_ops_pkg::file_wr_t file_wr,
	input  wire logic [15:0]           prog_addr,
	output logic [15:0]                prog_rdata
);
	logic [7:0] mem [256];
	// ===========================================================
	// combinational reads; program word differs at every address
	assign file_rdata = mem[rd_addr];
	assign prog_rdata = ~prog_addr;
	// file register write port, one byte per pulse
	always @(posedge hclk) begin
		if (file_wr.we === 1'b1) begin
			mem[file_wr.addr] <= file_wr.data;
		end
	end
endmodule

/* File: alu_multiply_subtract_ops_test.sv */
// self-checking bench for the multiply/subtract datapath
`timescale 1ns/1ps
module alu_multiply_subtract_ops_test;
	logic                  hclk, hresetn, hsel, hwrite, hready, hresp;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic [31:0]           haddr, hwdata, hrdata, rd;
	alu_ops_pkg::op_req_t  op;
	alu_ops_pkg::file_wr_t file_wr;
	logic [7:0]            file_rdata, working_value, e;
	logic [15:0]           prog_addr, prog_rdata;
	logic [11:0]           sm;
	logic [17:0]           sv [7];
	int                    bad_count = 0;
	int                    check_count = 0;
	int                    cyc = 0;

	alu_multiply_subtract_ops uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
		.hresp(hresp), .op(op), .file_rdata(file_rdata), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
		.file_wr(file_wr), .working_value(working_value));
	alu_ops_partner partner (.hclk(hclk), .rd_addr(op.operand), .file_rdata(file_rdata), .file_wr(file_wr),
		.prog_addr(prog_addr), .prog_rdata(prog_rdata));

	// ===========================================================
	// clock and hang guard
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end

	// ===========================================================
	// compare, bus cycle, operation and verdict
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		check_count = check_count + 1;
		if (g !== x) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		#1; // let a written register settle before callers look at outputs
	endtask
	task automatic run_op(input alu_ops_pkg::op_code_t c, input logic [7:0] a, input logic d, input logic [2:0] b,
		input logic [1:0] t);
		@(posedge hclk);
		op <= {1'b1, c, a, d, b, t};
		@(posedge hclk);
		op.valid <= 1'b0;
		#1;
	endtask
	function automatic logic [11:0] sub_model(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
		h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
		return {(a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ===========================================================
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		op = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h08, 32'h0);
		chk("reset flags", 32'h00000030, rd);
		chk("bus resp", 32'h0, {31'h0, hresp});
		// multiply by file, then by literal with flags preset
		bus(1'b1, 8'h00, 32'hC4);
		partner.mem[8'h40] = 8'hB5;
		run_op(alu_ops_pkg::multiply_working_by_file_op, 8'h40, 1'b0, 3'h0, 2'b00);
		chk("working kept", 32'h000000C4, {24'h0, working_value});
		bus(1'b0, 8'h04, 32'h0);
		chk("product file", 32'h00008A94, rd);
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, 8'h08, (i == 0) ? 32'h0 : 32'hB);
			run_op(alu_ops_pkg::multiply_literal_op, (i == 0) ? 8'h00 : 8'hAD, 1'b1, 3'h0, 2'b00);
			bus(1'b0, 8'h04, 32'h0);
			chk("product lit", {16'h0, 16'(8'hC4) * ((i == 0) ? 16'h0 : 16'hAD)}, rd);
			bus(1'b0, 8'h08, 32'h0);
			chk("mult flags", (i == 0) ? 32'h0 : 32'hB, {28'h0, rd[3:0]});
		end
		// invert to working register, then back to file
		for (int i = 0; i < 2; i++) begin
			bus(1'b1, 8'h08, 32'hB);
			partner.mem[8'h20] = (i == 0) ? 8'hFF : 8'h13;
			e = (i == 0) ? 8'h00 : 8'hEC;
			run_op(alu_ops_pkg::invert_file_op, 8'h20, i[0], 3'h0, 2'b00);
			chk("invert we", {31'h0, i[0]}, {31'h0, file_wr.we});
			chk("invert out", {24'h0, e}, {24'h0, (i == 0) ? working_value : file_wr.data});
			bus(1'b0, 8'h08, 32'h0);
			chk("invert flags", {28'h0, 1'b1, e == 8'h00, 2'b11}, {28'h0, rd[3:0]});
		end
		// set, clear and toggle one bit each
		partner.mem[8'h21] = 8'h5A;
		e = 8'h5A;
		for (int i = 0; i < 3; i++) begin
			e = (i == 0) ? (e | 8'h01) : (i == 1) ? (e & 8'hF7) : (e ^ 8'h80);
			run_op(alu_ops_pkg::op_code_t'(i), 8'h21, 1'b0, (i == 0) ? 3'h0 : (i == 1) ? 3'h3 : 3'h7, 2'b00);
			chk("bit op write", {15'h0, 1'b1, 8'h21, e}, {15'h0, file_wr});
		end
		// subtract table: borrow form, carry preset, file, working
		sv = '{{2'b00, 8'h03, 8'h02}, {2'b00, 8'h02, 8'h02}, {2'b00, 8'h01, 8'h02}, {2'b00, 8'h80, 8'h01},
			{2'b11, 8'h19, 8'h0D}, {2'b10, 8'h1B, 8'h1A}, {2'b11, 8'h03, 8'h0E}};
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, 8'h08, {31'h0, sv[i][16]});
			bus(1'b1, 8'h00, {24'h0, sv[i][7:0]});
			partner.mem[8'h30] = sv[i][15:8];
			sm = sub_model(sv[i][15:8], sv[i][7:0], sv[i][17] ? sv[i][16] : 1'b1);
			run_op(sv[i][17] ? alu_ops_pkg::subtract_with_borrow_op : alu_ops_pkg::subtract_working_from_file_op,
				8'h30, i == 6, 3'h0, 2'b00);
			chk("sub result", {24'h0, sm[7:0]}, {24'h0, (i == 6) ? file_wr.data : working_value});
			bus(1'b0, 8'h08, 32'h0);
			chk("sub flags", {28'h0, sm[11:8]}, {28'h0, rd[3:0]});
		end
		// table reads: low no step, high with step, low again
		bus(1'b1, 8'h0C, 32'hA356);
		chk("prog addr", 32'hA356, {16'h0, prog_addr});
		run_op(alu_ops_pkg::table_read_op, 8'h22, 1'b0, 3'h0, 2'b00);
		bus(1'b0, 8'h0C, 32'h0);
		chk("pointer held", 32'hA356, rd);
		run_op(alu_ops_pkg::table_read_op, 8'h22, 1'b0, 3'h0, 2'b11);
		chk("table high", {16'h0, 16'h015C}, {15'h0, file_wr.we, file_wr.data});
		bus(1'b0, 8'h0C, 32'h0);
		chk("pointer step", 32'hA357, rd);
		bus(1'b0, 8'h10, 32'h0);
		chk("latch", 32'h5CA9, rd);
		run_op(alu_ops_pkg::table_read_op, 8'h22, 1'b0, 3'h0, 2'b00);
		chk("table low", 32'h1A9, {23'h0, file_wr.we, file_wr.data});
		// let the watchdog expire, then clear it
		repeat (4200) @(posedge hclk);
		bus(1'b0, 8'h08, 32'h0);
		chk("expired", 32'h0, {31'h0, rd[5]});
		run_op(alu_ops_pkg::watchdog_clear_op, 8'h00, 1'b0, 3'h0, 2'b00);
		bus(1'b0, 8'h14, 32'h0);
		chk("wdt count", 32'h0, rd);
		bus(1'b0, 8'h08, 32'h0);
		chk("wdt flags", 32'h3, {30'h0, rd[5:4]});
		finish_test();
	end
endmodule
